/* rtl/tmc_pkg.sv */
// Constants, codes and decode helpers for the scan command and status core
package tmc_pkg;
    // Host register addresses
    localparam int unsigned ADDR_W       = 3;
    localparam logic [2:0]  ADDR_STATUS  = 3'h0;
    localparam logic [2:0]  ADDR_COMMAND = 3'h1;
    localparam logic [2:0]  ADDR_COUNT   = 3'h2;
    // Status bit positions
    localparam int unsigned ST_IN_NE     = 7;
    localparam int unsigned ST_OUT_FULL  = 6;
    localparam int unsigned ST_CNT_LD    = 5;
    // Command fields
    localparam int unsigned CMD_SOFT_FULL_RESET    = 7;
    localparam int unsigned CMD_TRST     = 6;
    localparam int unsigned CMD_END_LO   = 4;
    localparam int unsigned CMD_OP_LO    = 0;
    // Operation codes and the discrete mode code
    localparam logic [3:0]  OP_NULL      = 4'h0;
    localparam logic [3:0]  OP_RSVD      = 4'h1;
    localparam logic [3:0]  OP_RUN       = 4'h2;
    localparam logic [3:0]  OP_MOVE      = 4'h6;
    localparam logic [3:0]  OP_JUMP      = 4'h7;
    localparam logic [2:0]  MODE_DISCRETE = 3'h2;
    // Target state codes
    localparam logic [3:0]  TAP_TLR      = 4'h0;
    localparam logic [3:0]  TAP_SHIFT_DR = 4'h3;
    localparam logic [3:0]  TAP_PAUSE_DR = 4'h5;
    localparam logic [3:0]  TAP_RTI      = 4'h8;
    localparam logic [3:0]  TAP_SHIFT_IR = 4'hb;
    localparam logic [3:0]  TAP_PAUSE_IR = 4'hd;
    // Scan direction in opcode bits 2..1
    localparam logic [1:0]  SCAN_IN_ONLY  = 2'h1;
    localparam logic [1:0]  SCAN_OUT_ONLY = 2'h2;

    typedef enum logic [1:0] {
        TMC_IDLE = 2'b00,
        TMC_WAIT = 2'b01,
        TMC_RUN  = 2'b10
    } tmc_state_t;

    // Returns {uses_counter, uses_in_fifo, uses_out_fifo, has_work_state}
    function automatic logic [3:0] tmc_uses(input logic [3:0] op);
        logic [3:0] u;
        u = 4'h0;
        if (op[3]) begin
            u = {1'b1, op[2:1] != SCAN_OUT_ONLY, op[2:1] == 2'h0 || op[2:1] == SCAN_OUT_ONLY,
                 1'b1};
        end else if (op == OP_RUN) begin
            u = 4'h9;
        end else if (op > OP_RUN && op < OP_MOVE) begin
            u = {1'b1, op != 4'h5, op != 4'h3, 1'b0};
        end
        return u;
    endfunction

    function automatic logic [3:0] tmc_work(input logic [3:0] op);
        return (op == OP_RUN) ? TAP_RTI : (op[0] ? TAP_SHIFT_DR : TAP_SHIFT_IR);
    endfunction

    function automatic logic [3:0] tmc_final(input logic [1:0] sel);
        logic [3:0] s;
        case (sel)
            2'h0:    s = TAP_TLR;
            2'h1:    s = TAP_RTI;
            2'h2:    s = TAP_PAUSE_DR;
            default: s = TAP_PAUSE_IR;
        endcase
        return s;
    endfunction
endpackage

/* rtl/tmc_core.sv */
// Host command, status and cycle counter core of the scan master
`timescale 1ns/10ps
module tmc_core
    import tmc_pkg::*;
#(
    parameter int unsigned COUNT_W = 32
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // Asynchronous host bus
    input  wire logic               host_cs_n,
    input  wire logic               host_rd_n,
    input  wire logic               host_wr_n,
    input  wire logic [ADDR_W-1:0]  host_addr,
    input  wire logic [7:0]         host_din,
    output logic      [7:0]         host_dout,
    output logic                    host_dout_oe,
    output logic                    host_rdy,
    // FIFO and sequencer status
    input  wire logic               in_fifo_nonempty,
    input  wire logic               out_fifo_full,
    input  wire logic [3:0]         target_state_code,
    input  wire logic [2:0]         mode_code,
    input  wire logic               discrete_trst,
    input  wire logic               cmd_done,
    // Command hand-off to sequencer
    output logic                    cmd_start,
    output logic [3:0]              operation_code,
    output logic [3:0]              final_tap_state,
    output logic [3:0]              work_state,
    output logic [3:0]              cmd_uses,
    output logic [COUNT_W-1:0]      cmd_count,
    output logic                    fifo_flush,
    output logic                    soft_full_reset,
    // Target reset pin
    output logic                    test_reset_n
);
    localparam int unsigned PIN_W = 3 + ADDR_W + 8;
    localparam int unsigned NB    = COUNT_W / 8;
    localparam logic [1:0]  LAST  = 2'(NB - 1);

    // Three-stage pin capture, a bit changes once stages two and three agree
    logic [PIN_W-1:0] s1_r, s2_r, s3_r, filt_r;
    wire  [PIN_W-1:0] filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
    wire              cs     = !filt_r[PIN_W-1];
    wire              rd_act = cs && !filt_r[PIN_W-2];
    wire              wr_act = cs && !filt_r[PIN_W-3];
    wire [ADDR_W-1:0] addr_f = filt_r[8 +: ADDR_W];
    wire [7:0]        din_f  = filt_r[7:0];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_r   <= '1;
            s2_r   <= '1;
            s3_r   <= '1;
            filt_r <= '1;
        end else begin
            s1_r   <= {host_cs_n, host_rd_n, host_wr_n, host_addr, host_din};
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    // Cycle tracking; data and address held so a write commits at its end
    logic              rd_act_r, wr_act_r;
    logic [ADDR_W-1:0] wadr_r, radr_r;
    logic [7:0]        wdat_r;
    wire               wr_end = wr_act_r && !wr_act;
    wire               rd_end = rd_act_r && !rd_act;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_act_r <= 1'b0;
            wr_act_r <= 1'b0;
            wadr_r   <= '0;
            radr_r   <= '0;
            wdat_r   <= 8'h00;
        end else begin
            rd_act_r <= rd_act;
            wr_act_r <= wr_act;
            if (wr_act) begin
                wadr_r <= addr_f;
                wdat_r <= din_f;
            end
            if (rd_act) begin
                radr_r <= addr_f;
            end
        end
    end

    // Command decode
    tmc_state_t   state_r, state_nxt;
    logic [7:0]   cmd_r;
    logic         soft_rst_r, loaded_r;
    logic [COUNT_W-1:0] cnt_r;
    logic [1:0]   wptr_r, rptr_r;
    wire          busy       = state_r != TMC_IDLE;
    wire          discrete   = mode_code == MODE_DISCRETE;
    wire          cmd_wr_end = wr_end && wadr_r == ADDR_COMMAND;
    wire          soft_full_reset_wr   = cmd_wr_end && wdat_r[CMD_SOFT_FULL_RESET];
    // Writes other than a soft reset that end while busy are simply never committed
    wire          cmd_accept = cmd_wr_end && !soft_full_reset_wr && !busy && !discrete;
    wire [3:0]    new_op     = wdat_r[CMD_OP_LO +: 4];
    wire          new_real   = new_op != OP_NULL && new_op != OP_RSVD;
    wire [3:0]    cur_uses   = tmc_uses(cmd_r[CMD_OP_LO +: 4]);
    wire          start_ok   = state_r == TMC_WAIT && (!cur_uses[3] || loaded_r);
    wire          cnt_wr_end = wr_end && wadr_r == ADDR_COUNT && !busy;
    wire          cnt_rd_end = rd_end && radr_r == ADDR_COUNT;

    // Ready drops only for a non-reset command write while a command is waiting or running
    assign host_rdy = !(wr_act && addr_f == ADDR_COMMAND && busy && !din_f[CMD_SOFT_FULL_RESET]);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TMC_IDLE: begin
                if (cmd_accept && new_real) begin
                    state_nxt = TMC_WAIT;
                end
            end
            TMC_WAIT: begin
                if (start_ok) begin
                    state_nxt = TMC_RUN;
                end
            end
            TMC_RUN: begin
                if (cmd_done) begin
                    state_nxt = TMC_IDLE;
                end
            end
            default: state_nxt = TMC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r    <= TMC_IDLE;
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= soft_full_reset_wr;
            state_r    <= soft_rst_r ? TMC_IDLE : state_nxt;
        end
    end

    // Command register; a reserved opcode completes at once
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_r <= 8'h00;
        end else if (soft_rst_r) begin
            cmd_r <= 8'h00;
        end else if (cmd_accept) begin
            cmd_r <= new_real ? wdat_r : {wdat_r[7:4], OP_NULL};
        end else if (state_r == TMC_RUN && cmd_done) begin
            cmd_r[CMD_OP_LO +: 4] <= OP_NULL;
        end
    end

    // Counter window, least significant byte first
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r    <= '0;
            wptr_r   <= 2'h0;
            rptr_r   <= 2'h0;
            loaded_r <= 1'b0;
        end else if (soft_rst_r) begin
            cnt_r    <= '0;
            wptr_r   <= 2'h0;
            rptr_r   <= 2'h0;
            loaded_r <= 1'b0;
        end else begin
            if (cnt_wr_end) begin
                cnt_r[{wptr_r, 3'b000} +: 8] <= wdat_r;
                wptr_r   <= wptr_r + 2'h1;
                loaded_r <= wptr_r == LAST;
            end
            if (cnt_rd_end) begin
                rptr_r <= rptr_r + 2'h1;
            end
        end
    end

    // Hand-off to the sequencer; flush follows acceptance, the command fields are captured at start
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_start       <= 1'b0;
            fifo_flush      <= 1'b0;
            operation_code  <= OP_NULL;
            final_tap_state <= TAP_TLR;
            work_state      <= TAP_TLR;
            cmd_uses        <= 4'h0;
            cmd_count       <= '0;
        end else begin
            cmd_start  <= start_ok && !soft_rst_r;
            fifo_flush <= cmd_accept && new_real;
            if (start_ok) begin
                cmd_count       <= cnt_r;
                operation_code  <= cmd_r[CMD_OP_LO +: 4];
                final_tap_state <= tmc_final(cmd_r[CMD_END_LO +: 2]);
                work_state      <= tmc_work(cmd_r[CMD_OP_LO +: 4]);
                cmd_uses        <= cur_uses;
            end
        end
    end

    // Read data is live; no read changes any flag
    wire [7:0] status_byte = {in_fifo_nonempty, out_fifo_full, loaded_r, 1'b0,
                              target_state_code};
    wire [7:0] rd_mux = (addr_f == ADDR_STATUS)  ? status_byte :
                        (addr_f == ADDR_COMMAND) ? cmd_r :
                        (addr_f == ADDR_COUNT)   ? cnt_r[{rptr_r, 3'b000} +: 8] : 8'h00;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            host_dout     <= 8'h00;
            host_dout_oe  <= 1'b0;
            test_reset_n  <= 1'b1;
            soft_full_reset <= 1'b0;
        end else begin
            host_dout     <= rd_mux;
            host_dout_oe  <= rd_act;
            test_reset_n  <= discrete ? discrete_trst : !cmd_r[CMD_TRST];
            soft_full_reset <= soft_rst_r;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_status_live: assert property (rd_act && $past(rd_act) && addr_f == ADDR_STATUS &&
        $past(addr_f) == ADDR_STATUS |-> host_dout == {$past(in_fifo_nonempty),
        $past(out_fifo_full), $past(loaded_r), 1'b0, $past(target_state_code)})
        else $error("status read does not return live flags");
    a_wait_loaded: assert property (cmd_start |-> $past(loaded_r) || !cmd_uses[3])
        else $error("counter command started without a loaded counter");
    a_cmd_held: assert property (busy && $past(busy) && !$past(soft_rst_r) |->
        $stable(cmd_r))
        else $error("command byte changed while running");
    a_done_null: assert property (state_r == TMC_RUN && cmd_done && !soft_rst_r |=>
        cmd_r[3:0] == OP_NULL && state_r == TMC_IDLE)
        else $error("opcode not cleared at completion");
    a_rdy_hold: assert property (wr_act && addr_f == ADDR_COMMAND && busy &&
        !din_f[CMD_SOFT_FULL_RESET] |-> !host_rdy)
        else $error("ready not held during busy command write");
    a_busy_discard: assert property (cmd_wr_end && busy && !soft_full_reset_wr && !soft_rst_r &&
        !(state_r == TMC_RUN && cmd_done) |=> $stable(cmd_r))
        else $error("command write taken while busy");
    a_soft_reset: assert property (soft_full_reset_wr |=> ##1 state_r == TMC_IDLE && !loaded_r &&
        cmd_r == 8'h00)
        else $error("software reset did not clear the core");
    a_trst_drive: assert property (!discrete && $stable(cmd_r) |=>
        test_reset_n == !$past(cmd_r[CMD_TRST]) || discrete)
        else $error("test reset does not follow command bit");
    a_load_four: assert property ($rose(loaded_r) |-> $past(cnt_wr_end) &&
        $past(wptr_r) == LAST)
        else $error("counter flagged loaded before fourth byte");
    a_read_keeps: assert property (cnt_rd_end && !cnt_wr_end && !soft_rst_r |=>
        $stable(loaded_r))
        else $error("counter read altered loaded flag");
    a_busy_drop: assert property (wr_end && wadr_r == ADDR_COUNT && busy && !soft_rst_r |=>
        $stable(cnt_r))
        else $error("counter changed by write during command");
    a_count_capture: assert property (start_ok && !soft_rst_r |=> cmd_start &&
        cmd_count == $past(cnt_r))
        else $error("counter not captured at start");
    a_flush_start: assert property (state_r == TMC_WAIT && $past(state_r) == TMC_IDLE &&
        !$past(soft_rst_r) |-> fifo_flush)
        else $error("FIFOs not flushed at command start");
    a_discrete_idle: assert property (discrete && cmd_wr_end && !soft_full_reset_wr && !busy |=>
        state_r == TMC_IDLE)
        else $error("command started in discrete mode");

    c_run_cmd: cover property (cmd_start ##[1:1000] (state_r == TMC_RUN && cmd_done));
    c_busy_write: cover property (wr_act && !host_rdy);
    c_count_load: cover property ($rose(loaded_r));
    c_soft_reset: cover property (soft_full_reset_wr && busy);
    c_discrete: cover property (discrete && cmd_wr_end);
endmodule

/* testbench/tmc_seq_model.sv */
// Sequencer and FIFO stand-in facing the command core
`timescale 1ns/10ps
module tmc_seq_model
    import tmc_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // From the core
    input  wire logic       cmd_start,
    input  wire logic       fifo_flush,
    input  wire logic       soft_full_reset,
    input  wire logic [3:0] final_tap_state,
    // Bench controls
    input  wire logic       in_set,
    input  wire logic       out_set,
    input  wire logic       st_set,
    input  wire logic [3:0] st_val,
    input  wire logic [7:0] done_dly,
    // To the core
    output logic            in_fifo_nonempty,
    output logic            out_fifo_full,
    output logic [3:0]      target_state_code,
    output logic            cmd_done
);
    logic       busy_r;
    logic [7:0] cnt_r;
    logic [3:0] fin_r;

    // Done only after a start, so a late pulse cannot end a newer command
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            in_fifo_nonempty  <= 1'b0;
            out_fifo_full     <= 1'b0;
            target_state_code <= TAP_TLR;
            cmd_done          <= 1'b0;
            busy_r            <= 1'b0;
            cnt_r             <= 8'h00;
            fin_r             <= TAP_TLR;
        end else begin
            cmd_done <= 1'b0;
            if (in_set) in_fifo_nonempty <= 1'b1;
            if (out_set) out_fifo_full <= 1'b1;
            if (st_set) target_state_code <= st_val;
            if (fifo_flush || soft_full_reset) begin
                in_fifo_nonempty <= 1'b0;
                out_fifo_full    <= 1'b0;
            end
            if (soft_full_reset) begin
                busy_r <= 1'b0;
            end else if (cmd_start) begin
                busy_r <= 1'b1;
                cnt_r  <= done_dly;
                fin_r  <= final_tap_state;
            end else if (busy_r && cnt_r == 8'h00) begin
                busy_r            <= 1'b0;
                cmd_done          <= 1'b1;
                target_state_code <= fin_r;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule

/* testbench/tb.sv */
// Self-checking bench for the scan command and status core
`timescale 1ns/10ps
module tb;
    import tmc_pkg::*;
    localparam logic [31:0] CV = 32'ha1b2c3d4;
    localparam logic [3:0] USES [16] = '{4'h0, 4'h0, 4'h9, 4'hc, 4'he, 4'ha, 4'h0, 4'h0,
                                          4'hf, 4'hf, 4'hd, 4'hd, 4'hb, 4'hb, 4'hd, 4'hd};
    localparam logic [3:0] FIN [4] = '{TAP_TLR, TAP_RTI, TAP_PAUSE_DR, TAP_PAUSE_IR};
    logic        ref_clk, rst, cs_n, rd_n, wr_n, oe, rdy, in_ne, out_f, done, start;
    logic        flush, swr, dtrst, trst_n, in_set, out_set, st_set, r;
    logic [2:0]  addr, mode;
    logic [7:0]  din, dout, rdv, dly;
    logic [3:0]  tsc, op_o, fin_o, work_o, uses_o, st_val, s_op, s_fin, s_work, s_uses;
    logic [31:0] cnt_o, s_cnt;
    int          error_cnt, num_checks, n_start, n_flush, n_swr;

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    tmc_core u_dut (.ref_clk(ref_clk), .rst(rst), .host_cs_n(cs_n), .host_rd_n(rd_n),
        .host_wr_n(wr_n), .host_addr(addr), .host_din(din), .host_dout(dout),
        .host_dout_oe(oe), .host_rdy(rdy), .in_fifo_nonempty(in_ne), .out_fifo_full(out_f),
        .target_state_code(tsc), .mode_code(mode), .discrete_trst(dtrst), .cmd_done(done),
        .cmd_start(start), .operation_code(op_o), .final_tap_state(fin_o),
        .work_state(work_o), .cmd_uses(uses_o), .cmd_count(cnt_o), .fifo_flush(flush),
        .soft_full_reset(swr), .test_reset_n(trst_n));
    tmc_seq_model u_seq (.ref_clk(ref_clk), .rst(rst), .cmd_start(start),
        .fifo_flush(flush), .soft_full_reset(swr), .final_tap_state(fin_o),
        .in_set(in_set), .out_set(out_set), .st_set(st_set), .st_val(st_val),
        .done_dly(dly), .in_fifo_nonempty(in_ne), .out_fifo_full(out_f),
        .target_state_code(tsc), .cmd_done(done));

    // Pulses are caught at the falling edge, where registered outputs are settled
    always @(negedge ref_clk) begin
        if (start === 1'b1) begin
            n_start++;
            {s_op, s_fin, s_work, s_uses, s_cnt} = {op_o, fin_o, work_o, uses_o, cnt_o};
        end
        if (flush === 1'b1) n_flush++;
        if (swr === 1'b1) n_swr++;
    end

    task automatic results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Strobes stay low well beyond the filter; a dropped write is let go early
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input bit drop,
                      output logic rd6);
        int n;
        @(posedge ref_clk);
        {cs_n, wr_n, addr, din} <= {1'b0, 1'b0, a, d};
        repeat (6) @(negedge ref_clk);
        rd6 = rdy;
        n = 0;
        while (!drop && rdy !== 1'b1) begin
            @(negedge ref_clk);
            n++;
            if (n > 200) begin
                error_cnt++;
                $display("ERROR %0t ready never came", $time);
                results();
            end
        end
        @(posedge ref_clk);
        {cs_n, wr_n} <= 2'b11;
        tick(8);
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        {cs_n, rd_n, addr} <= {1'b0, 1'b0, a};
        repeat (8) @(negedge ref_clk);
        d = dout;
        chk(oe, 1, "read bus enable");
        @(posedge ref_clk);
        {cs_n, rd_n} <= 2'b11;
        tick(8);
    endtask

    task automatic poke(input logic i, input logic o, input logic [3:0] s);
        @(posedge ref_clk);
        {in_set, out_set, st_set, st_val} <= {i, o, 1'b1, s};
        @(posedge ref_clk);
        {in_set, out_set, st_set} <= 3'b000;
    endtask

    task automatic t_soft_full_reset;
        rd(ADDR_STATUS, rdv);
        chk(rdv[ST_CNT_LD], 0, "loaded after reset");
        wr(ADDR_COMMAND, 8'h12, 0, r);
        tick(30);
        chk(n_start, 0, "start with counter unloaded");
        wr(ADDR_COMMAND, 8'h80, 0, r);
        chk(r, 1, "soft reset refused");
        chk(n_swr, 1, "soft reset pulse");
        rd(ADDR_COMMAND, rdv);
        chk(rdv, 8'h00, "command after soft reset");
    endtask

    task automatic t_status;
        logic [7:0] v2;
        for (int i = 0; i < 16; i++) begin
            poke(0, 0, i[3:0]);
            rd(ADDR_STATUS, rdv);
            chk(rdv, {4'h0, i[3:0]}, "status state code");
        end
        poke(1, 0, TAP_RTI);
        rd(ADDR_STATUS, rdv);
        chk(rdv, 8'h88, "input fifo flag");
        poke(0, 1, TAP_RTI);
        rd(ADDR_STATUS, rdv);
        rd(ADDR_STATUS, v2);
        chk(rdv, 8'hc8, "output fifo flag");
        chk(v2, rdv, "status read side effect");
        rd(3'h7, rdv);
        chk(rdv, 8'h00, "unmapped read");
        chk(oe, 0, "read bus released");
    endtask

    task automatic t_count;
        for (int b = 0; b < 4; b++) begin
            wr(ADDR_COUNT, CV[8*b+:8], 0, r);
            rd(ADDR_STATUS, rdv);
            chk(rdv[ST_CNT_LD], b == 3, "loaded flag during load");
        end
        for (int b = 0; b < 4; b++) begin
            rd(ADDR_COUNT, rdv);
            chk(rdv, CV[8*b+:8], "counter byte order");
        end
        rd(ADDR_STATUS, rdv);
        chk(rdv[ST_CNT_LD], 1, "loaded flag after reads");
    endtask

    task automatic t_run;
        int nf;
        nf = n_flush;
        dly <= 8'hc8;
        wr(ADDR_COMMAND, 8'h12, 0, r);
        chk(n_start, 1, "run test start");
        chk(s_cnt, CV, "captured count");
        chk({s_fin, s_work, s_uses}, {TAP_RTI, TAP_RTI, 4'h9}, "run test decode");
        chk(n_flush, nf + 1, "flush on start");
        rd(ADDR_STATUS, rdv);
        chk(rdv[7:6], 2'b00, "fifos after start");
        rd(ADDR_COMMAND, rdv);
        chk(rdv, 8'h12, "command while busy");
        wr(ADDR_COUNT, 8'h00, 0, r);
        wr(ADDR_COMMAND, 8'h19, 1, r);
        chk(r, 0, "ready during busy write");
        rdv = 8'h12;
        for (int k = 0; k < 30 && rdv[3:0] != OP_NULL; k++) rd(ADDR_COMMAND, rdv);
        chk(rdv, 8'h10, "completion clears opcode");
        chk(n_start, 1, "dropped write started");
        for (int b = 0; b < 4; b++) begin
            rd(ADDR_COUNT, rdv);
            chk(rdv, CV[8*b+:8], "counter write while busy");
        end
    endtask

    task automatic t_ops;
        int n0;
        logic [1:0] e;
        dly <= 8'h02;
        for (int op = 0; op < 16; op++) begin
            n0 = n_start;
            e = op[1:0];
            wr(ADDR_COMMAND, {2'b00, e, op[3:0]}, 0, r);
            tick(6);
            rd(ADDR_COMMAND, rdv);
            chk(rdv, {2'b00, e, 4'h0}, "opcode after finish");
            chk(n_start, n0 + (op > 1), "start per opcode");
            if (op > 1) begin
                chk(s_op, op, "started opcode");
                chk(s_uses, USES[op], "resource usage");
                chk(s_fin, FIN[e], "end state select");
                if (op == 2 || op > 7)
                    chk(s_work, op == 2 ? TAP_RTI : (op % 2 ? TAP_SHIFT_DR : TAP_SHIFT_IR),
                        "working state");
            end
        end
    endtask

    task automatic t_trst;
        int n0;
        wr(ADDR_COMMAND, 8'h40, 0, r);
        chk(trst_n, 0, "test reset asserted");
        wr(ADDR_COMMAND, 8'h00, 0, r);
        chk(trst_n, 1, "test reset released");
        n0 = n_start;
        @(posedge ref_clk);
        mode <= MODE_DISCRETE;
        dtrst <= 1'b0;
        wr(ADDR_COMMAND, 8'h12, 0, r);
        tick(10);
        chk(n_start, n0, "start in discrete mode");
        chk(trst_n, 0, "discrete test reset level");
        rd(ADDR_COMMAND, rdv);
        chk(rdv, 8'h00, "command taken in discrete mode");
        @(posedge ref_clk);
        mode <= 3'h0;
        dtrst <= 1'b1;
    endtask

    initial begin
        {rst, cs_n, rd_n, wr_n, addr, din, mode, dtrst} = {4'hf, 3'h0, 8'h00, 3'h0, 1'b1};
        {in_set, out_set, st_set, st_val, dly} = {3'h0, 4'h0, 8'h02};
        {error_cnt, num_checks, n_start, n_flush, n_swr} = '0;
        tick(2);
        rst <= 1'b0;
        tick(4);
        t_soft_full_reset();
        t_status();
        t_count();
        t_run();
        t_ops();
        t_trst();
        results();
    end
endmodule
